// File: page_read_seq.sv
`timescale 1ns/1ps
// Contract
// - Slow-mode transfer in flight finishes at new rate with slow-mode timings.
// - First read opening a page lasts the chip-select read pulse length.
// - In-page reads last the read-strobe pulse length; other settings are ignored.
// - Timings are applied as programmed, never checked for coherency.
// - Same chip select and same upper page bits means same page.
// - Every in-page read, sequential or not, uses the short duration.
// - Different upper page bits start a new page with the long duration.
// - Different chip select is a page break using the long duration.
// - Any intervening other access forces a page break on the next read.
module page_read_seq
    import page_read_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic REQ_VALID,
    input wire logic [CS_W-1:0] REQ_CS,
    input wire logic [ADDR_W-1:0] REQ_ADDR,
    input wire logic OTHER_ACCESS,
    input wire logic PAGE_MODE,
    input wire logic SLOW_MODE,
    input wire logic [LEN_W-1:0] CS_READ_PULSE_LEN,
    input wire logic [LEN_W-1:0] READ_STROBE_PULSE_LEN,
    input wire logic [LEN_W-1:0] SLOW_CS_READ_PULSE_LEN,
    input wire logic [LEN_W-1:0] SLOW_READ_STROBE_PULSE_LEN,
    input wire logic [LEN_W-1:0] CS_READ_SETUP_LEN,
    input wire logic [LEN_W-1:0] READ_STROBE_SETUP_LEN,
    input wire logic [LEN_W-1:0] READ_CYCLE_LEN,
    input wire logic EXTERNAL_WAIT_INPUT,
    output logic REQ_READY,
    output logic [CS_W-1:0] MEM_CS,
    output logic MEM_CS_ACTIVE,
    output logic MEM_READ_STROBE,
    output logic [ADDR_W-1:0] MEM_ADDR,
    output logic DONE,
    output logic PAGE_BREAK,
    output logic SLOW_TIMING
);
    // ****************************************************************
    // Internal state
    // ****************************************************************
    seq_state_type state;
    logic [LEN_W-1:0] count;
    logic hit;
    logic start;
    logic next_slow;
    logic [LEN_W-1:0] next_len;
    logic page_lost;
    logic pulse_end;
    logic wait_meta;
    logic wait_sync;

    // Setup and cycle lengths and the wait input play no part in page mode
    logic unused;
    assign unused = ^{CS_READ_SETUP_LEN, READ_STROBE_SETUP_LEN, READ_CYCLE_LEN,
                      wait_sync};

    // ****************************************************************
    // Wait pin synchroniser
    // ****************************************************************
    // The pin is asynchronous to the clock, so it passes two flops even
    // though page mode gives it no effect on the access
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            wait_meta <= 1'b0;
            wait_sync <= 1'b0;
        end else if (CE) begin
            wait_meta <= EXTERNAL_WAIT_INPUT;
            wait_sync <= wait_meta;
        end
    end

    // ****************************************************************
    // Take decision
    // ****************************************************************
    // A request is taken only in idle and only while page mode is on
    assign start = (state == ST_IDLE) && REQ_VALID && PAGE_MODE;

    // Another access or leaving page mode ends the page, and deasserts the chip select outside a take or strobe pulse
    assign page_lost = OTHER_ACCESS || !PAGE_MODE;

    // Last enabled cycle of the strobe pulse
    assign pulse_end = (state == ST_PULSE) && (count == LEN_ONE);

    // Timing set is latched at start, so a mode change mid-transfer keeps it
    assign next_slow = SLOW_MODE;

    // Pick the pulse length; no coherency check between the two
    always_comb begin
        if (hit) begin
            next_len = next_slow ? SLOW_READ_STROBE_PULSE_LEN
                                 : READ_STROBE_PULSE_LEN;
        end else begin
            next_len = next_slow ? SLOW_CS_READ_PULSE_LEN
                                 : CS_READ_PULSE_LEN;
        end
        if (next_len == LEN_ZERO) begin
            next_len = LEN_ONE;
        end
    end

    // ****************************************************************
    // Page tracking
    // ****************************************************************
    page_tracker u_tracker (
        .clk(CLOCK),
        .rst_n(RST_N),
        .ce(CE),
        .cs(REQ_CS),
        .addr(REQ_ADDR),
        .load(start),
        .invalidate(page_lost),
        .hit(hit)
    );

    // ****************************************************************
    // Access sequencer
    // ****************************************************************
    // Idle, then the strobe pulse, then one turnaround cycle before idle
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state <= ST_IDLE;
        end else if (CE) begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    if (pulse_end) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Pulse counter: loaded with the chosen length at take, then counted
    // down in controller cycles at whatever rate is running now
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            count <= LEN_ZERO;
        end else if (CE) begin
            if (start) begin
                count <= next_len;
            end else if (state == ST_PULSE && !pulse_end) begin
                count <= count - LEN_ONE;
            end
        end
    end

    // ****************************************************************
    // Memory side pins
    // ****************************************************************
    // Chip select and address are captured at take and held to the next take
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            MEM_CS <= '0;
            MEM_ADDR <= '0;
        end else if (CE && start) begin
            MEM_CS <= REQ_CS;
            MEM_ADDR <= REQ_ADDR;
        end
    end

    // Read strobe stands for exactly the chosen number of enabled cycles
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            MEM_READ_STROBE <= 1'b0;
        end else if (CE) begin
            if (start) begin
                MEM_READ_STROBE <= 1'b1;
            end else if (pulse_end) begin
                MEM_READ_STROBE <= 1'b0;
            end
        end
    end

    // Chip select drops when the bus is lost, but never inside a strobe pulse
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            MEM_CS_ACTIVE <= 1'b0;
        end else if (CE) begin
            if (start) begin
                MEM_CS_ACTIVE <= 1'b1;
            end else if (page_lost && state != ST_PULSE) begin
                MEM_CS_ACTIVE <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Status flags and handshake pulses
    // ****************************************************************
    // Page break and timing set describe the last read taken; an access in
    // the take cycle itself is flagged as a break too, though the take keeps the chip select asserted
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            PAGE_BREAK <= 1'b0;
            SLOW_TIMING <= 1'b0;
        end else if (CE && start) begin
            PAGE_BREAK <= !hit || OTHER_ACCESS;
            SLOW_TIMING <= next_slow;
        end
    end

    // Take and completion are one-cycle pulses
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            REQ_READY <= 1'b0;
            DONE <= 1'b0;
        end else if (CE) begin
            REQ_READY <= start;
            DONE <= pulse_end;
        end
    end
endmodule // page_read_seq

// File: page_read_pkg.sv
package page_read_pkg;
    // ****************************************************************
    // Widths and sizes
    // ****************************************************************
    localparam int ADDR_W = 24;
    localparam int CS_W = 2;
    localparam int LEN_W = 6;
    // Page size in bytes as a power of two (8-byte pages)
    localparam int PAGE_LOG2 = 3;
    localparam logic [LEN_W-1:0] LEN_ONE = 6'h01;
    localparam logic [LEN_W-1:0] LEN_ZERO = 6'h00;

    // ****************************************************************
    // Access sequencer states
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PULSE,
        ST_DONE
    } seq_state_type;
endpackage

// File: page_tracker.sv
`timescale 1ns/1ps
// ********************************************************************
// Page tracking register and page-hit compare
// ********************************************************************
module page_tracker
    import page_read_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [CS_W-1:0] cs,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic load,
    input wire logic invalidate,
    output logic hit
);
    logic valid;
    logic [CS_W-1:0] last_cs;
    logic [ADDR_W-PAGE_LOG2-1:0] last_page;

    // Valid page with same chip select and same upper page bits means no page break
    assign hit = valid && (last_cs == cs)
                 && (last_page == addr[ADDR_W-1:PAGE_LOG2]);

    // Tracker is cleared at reset so the first read opens a page
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid <= 1'b0;
            last_cs <= '0;
            last_page <= '0;
        end else if (ce) begin
            if (invalidate) begin
                valid <= 1'b0;
            end else if (load) begin
                valid <= 1'b1;
                last_cs <= cs;
                last_page <= addr[ADDR_W-1:PAGE_LOG2];
            end
        end
    end
endmodule // page_tracker

// File: page_mem_model.sv
`timescale 1ns/1ps
module page_mem_model
    import page_read_pkg::*;
(
    input wire logic clk,
    input wire logic strobe,
    output logic wait_out,
    output logic [LEN_W-1:0] last_len
);
    logic [LEN_W-1:0] run;
    // The wait line stays idle because page mode is in use
    assign wait_out = 1'b0;
    // Access time seen at the device pins, kept after the strobe falls
    always_ff @(posedge clk) begin
        run <= strobe ? run + 6'h01 : 6'h00;
        if (!strobe && run != 6'h00) last_len <= run;
    end
endmodule // page_mem_model

// File: page_read_properties.sv
`timescale 1ns/1ps
module page_read_properties
    import page_read_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic OTHER_ACCESS,
    input wire logic PAGE_MODE,
    input wire logic [LEN_W-1:0] CS_READ_PULSE_LEN,
    input wire logic [LEN_W-1:0] READ_STROBE_PULSE_LEN,
    input wire logic REQ_READY,
    input wire logic MEM_CS_ACTIVE,
    input wire logic MEM_READ_STROBE,
    input wire logic DONE,
    input wire logic PAGE_BREAK,
    input wire logic SLOW_TIMING
);
    logic [LEN_W-1:0] cnt, sel, want;
    logic dirty;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // Expected strobe length in normal timing, zero runs as one
    assign sel = PAGE_BREAK ? CS_READ_PULSE_LEN : READ_STROBE_PULSE_LEN;
    assign want = (sel == LEN_ZERO) ? LEN_ONE : sel;
    // Strobe cycles of the read, and a flag for a lost page
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            cnt <= LEN_ZERO;
            dirty <= 1'b1;
        end else if (CE) begin
            cnt <= REQ_READY ? LEN_ONE : cnt + {5'h00, MEM_READ_STROBE};
            dirty <= OTHER_ACCESS || !PAGE_MODE || (dirty && !REQ_READY);
        end
    end
    a_ready_single: assert property (REQ_READY |=> !REQ_READY)
        else $error("ready too long");
    a_strobe_start: assert property ($rose(MEM_READ_STROBE) |-> REQ_READY && MEM_CS_ACTIVE)
        else $error("strobe without take");
    a_access_len: assert property (DONE && !SLOW_TIMING |-> cnt == want)
        else $error("wrong access length");
    a_done_single: assert property (DONE |=> !DONE)
        else $error("done too long");
    a_strobe_end: assert property ($fell(MEM_READ_STROBE) |-> DONE)
        else $error("strobe end without done");
    a_break_dirty: assert property (REQ_READY && dirty |-> PAGE_BREAK)
        else $error("missing page break");
    a_slow_kept: assert property (MEM_READ_STROBE && !REQ_READY |-> $stable(SLOW_TIMING))
        else $error("timing set changed");
    a_break_held: assert property (MEM_READ_STROBE && !REQ_READY |-> $stable(PAGE_BREAK))
        else $error("break flag changed");
    c_hit: cover property (REQ_READY && !PAGE_BREAK);
    c_slow: cover property (REQ_READY && SLOW_TIMING);
    c_other: cover property (OTHER_ACCESS ##[1:9] REQ_READY && PAGE_BREAK);
endmodule // page_read_properties
bind page_read_seq page_read_properties chk (.*);

// File: page_read_seq_tb.sv
`timescale 1ns/1ps
module page_read_seq_tb
    import page_read_pkg::*;
;
    logic CLOCK = 1'b0, RST_N = 1'b0, CE = 1'b1, REQ_VALID = 1'b0, OTHER_ACCESS = 1'b0;
    logic PAGE_MODE = 1'b1, SLOW_MODE = 1'b0;
    logic [CS_W-1:0] REQ_CS = 2'h0, MEM_CS;
    logic [ADDR_W-1:0] REQ_ADDR = 24'h000000, MEM_ADDR;
    logic [LEN_W-1:0] CS_READ_PULSE_LEN = 6'h03, READ_STROBE_PULSE_LEN = 6'h02, seen_len;
    logic [LEN_W-1:0] SLOW_CS_READ_PULSE_LEN = 6'h05, SLOW_READ_STROBE_PULSE_LEN = 6'h04;
    logic [LEN_W-1:0] CS_READ_SETUP_LEN = 6'h3f, READ_STROBE_SETUP_LEN = 6'h2a;
    logic [LEN_W-1:0] READ_CYCLE_LEN = 6'h01;
    logic EXTERNAL_WAIT_INPUT, REQ_READY, MEM_CS_ACTIVE, MEM_READ_STROBE, DONE, PAGE_BREAK;
    logic SLOW_TIMING;
    int bad_count = 0, n_compared = 0;
    page_read_seq uut (.*);
    page_mem_model mem (.clk(CLOCK), .strobe(MEM_READ_STROBE), .wait_out(EXTERNAL_WAIT_INPUT),
        .last_len(seen_len));
    // Clock generator
    always #25 CLOCK = ~CLOCK;
    // Verdict and end of run
    task complete_run;
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Compare with expected value
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait for ready or done
    task automatic wait_on(input bit sel);
        for (int i = 0; i < 20; i++) begin
            @(posedge CLOCK);
            #1;
            if ((sel ? DONE : REQ_READY) === 1'b1) return;
        end
        bad_count++;
        complete_run();
    endtask
    // One other access or page mode gap of one cycle
    task gap(input logic o, input logic p);
        OTHER_ACCESS = o;
        PAGE_MODE = p;
        @(posedge CLOCK);
        #1;
        chk({7'h00, MEM_CS_ACTIVE}, 8'h00);
        OTHER_ACCESS = 1'b0;
        PAGE_MODE = 1'b1;
    endtask
    // Request held while the clock enable is low must not be taken
    task frz(input logic [CS_W-1:0] cs, input logic [ADDR_W-1:0] a);
        REQ_CS = cs;
        REQ_ADDR = a;
        REQ_VALID = 1'b1;
        CE = 1'b0;
        repeat (2) begin
            @(posedge CLOCK);
            #1;
            chk({7'h00, REQ_READY}, 8'h00);
        end
        CE = 1'b1;
    endtask
    // One read; slow mode is dropped as soon as the read is taken
    task rd(input logic [CS_W-1:0] cs, input logic [ADDR_W-1:0] a, input logic s,
        input logic [7:0] len, input logic brk);
        REQ_CS = cs;
        REQ_ADDR = a;
        SLOW_MODE = s;
        REQ_VALID = 1'b1;
        wait_on(1'b0);
        REQ_VALID = 1'b0;
        SLOW_MODE = 1'b0;
        chk({7'h00, PAGE_BREAK}, {7'h00, brk});
        chk({7'h00, SLOW_TIMING}, {7'h00, s});
        chk({6'h00, MEM_CS}, {6'h00, cs});
        chk(MEM_ADDR[15:8], a[15:8]);
        chk(MEM_ADDR[7:0], a[7:0]);
        chk({7'h00, MEM_CS_ACTIVE}, 8'h01);
        wait_on(1'b1);
        @(posedge CLOCK);
        #1;
        chk({2'h0, seen_len}, len);
        $display("read %h done", a);
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge CLOCK);
        #1;
        RST_N = 1'b1;
        rd(2'h0, 24'h000010, 1'b0, 8'h03, 1'b1);
        rd(2'h0, 24'h000013, 1'b0, 8'h02, 1'b0);
        rd(2'h0, 24'h000017, 1'b0, 8'h02, 1'b0);
        rd(2'h0, 24'h000018, 1'b0, 8'h03, 1'b1);
        rd(2'h1, 24'h000018, 1'b0, 8'h03, 1'b1);
        gap(1'b1, 1'b1);
        rd(2'h1, 24'h000019, 1'b0, 8'h03, 1'b1);
        gap(1'b0, 1'b0);
        rd(2'h1, 24'h00001a, 1'b0, 8'h03, 1'b1);
        CS_READ_PULSE_LEN = 6'h01;
        READ_STROBE_PULSE_LEN = 6'h04;
        CS_READ_SETUP_LEN = 6'h00;
        rd(2'h2, 24'h000100, 1'b0, 8'h01, 1'b1);
        frz(2'h2, 24'h000105);
        rd(2'h2, 24'h000105, 1'b0, 8'h04, 1'b0);
        rd(2'h3, 24'h000200, 1'b1, 8'h05, 1'b1);
        rd(2'h3, 24'h000201, 1'b1, 8'h04, 1'b0);
        complete_run();
    end
endmodule // page_read_seq_tb
